// File: rtl/lmie_core.sv
// Purpose: executes literal, move, indirect-store, nop, reset and return instructions
// Assumes: software feeds one instruction word at a time over AXI4-Lite
// Notes: data memory is internal; status flags are held, never computed here
`timescale 1ns/1ps
// Contract
// - bank literal load copies 5-bit value into bank select, flags untouched.
// - page literal load copies 7-bit value into pc high latch, flags untouched.
// - accumulator literal load puts 8-bit value in accumulator, one cycle, no flags.
// - accumulator store writes accumulator to file address 0..127, no flags.
// - indirect store picks a pointer; 2-bit code chooses pre/post increment/decrement.
// - relative form addresses pointer plus signed -32..31 offset, pointer kept.
// - afterwards pointer is plus one, minus one, or unchanged for relative.
// - pre modes update before addressing; post modes address with old value.
// - accessing an indirect window register reaches memory at its pointer.
// - pointer stepping wraps within 16 bits.
// - indirect store and pointer stepping change no status flag.
// - software reset acts as hardware reset and clears the reset-instruction flag; held instruction and software memory address are kept.
// - return from interrupt pops stack into pc and sets enable bit 7.
// - return from interrupt takes two cycles and leaves flags alone.
module lmie_core
#(
    parameter int MEM_AW = 9,
    parameter int STACK_DEPTH = 16
)
(
    // clock and reset
    input wire logic CLK,
    input wire logic RST,
    // write address channel
    input wire logic AWVALID,
    output logic AWREADY,
    input wire logic [7:0] AWADDR,
    // write data channel
    input wire logic WVALID,
    output logic WREADY,
    input wire logic [31:0] WDATA,
    input wire logic [3:0] WSTRB,
    // write response channel
    output logic BVALID,
    input wire logic BREADY,
    output logic [1:0] BRESP,
    // read address channel
    input wire logic ARVALID,
    output logic ARREADY,
    input wire logic [7:0] ARADDR,
    // read data channel
    output logic RVALID,
    input wire logic RREADY,
    output logic [31:0] RDATA,
    output logic [1:0] RRESP
);
    import lmie_pkg::*;

    localparam int SP_W = $clog2(STACK_DEPTH);

    // opcode decode, used by execution and by the sequencer; busy readback uses the state alone
    function automatic lmie_op_t decode(input logic [13:0] i);
        if ((i & MSK_FULL) == OPC_NOP) return OP_NOP;
        if ((i & MSK_FULL) == OPC_RESET) return OP_RESET;
        if ((i & MSK_FULL) == OPC_RETIRQ) return OP_RETIRQ;
        if ((i & MSK_LDBANK) == OPC_LDBANK) return OP_LDBANK;
        if ((i & MSK_7BIT) == OPC_LDPAGE) return OP_LDPAGE;
        if ((i & MSK_LDACC) == OPC_LDACC) return OP_LDACC;
        if ((i & MSK_7BIT) == OPC_STF) return OP_STF;
        if ((i & MSK_STIND) == OPC_STIND) return OP_STIND;
        if ((i & MSK_7BIT) == OPC_STREL) return OP_STREL;
        return OP_UNKNOWN;
    endfunction : decode

    lmie_state_t state_q;
    logic [13:0] instr_q;
    logic [7:0] wreg_q;
    logic [4:0] bank_q;
    logic [6:0] pglat_q;
    logic [15:0] fsr0_q;
    logic [15:0] fsr1_q;
    logic [14:0] pc_q;
    logic [7:0] irqctl_q;
    logic [7:0] status_q;
    logic rf_q;
    logic [SP_W-1:0] sp_q;
    logic [14:0] stack_q [STACK_DEPTH];
    logic [7:0] mem_q [2**MEM_AW];
    logic [MEM_AW-1:0] maddr_q;
    logic aw_held_q, w_held_q;
    logic [7:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;

    // bus write strobe and decode
    logic wr_go, wr_ok;
    logic wr_instr, wr_irqctl, wr_status, wr_pwrc, wr_push, wr_maddr, wr_mdata;
    assign wr_go = aw_held_q && w_held_q && !BVALID;
    assign wr_ok = (wstrb_q == 4'hf);
    // a new instruction is only taken when nothing is executing
    assign wr_instr = wr_go && wr_ok && awaddr_q == REG_INSTR && state_q == ST_IDLE;
    assign wr_irqctl = wr_go && wr_ok && awaddr_q == REG_IRQCTL;
    assign wr_status = wr_go && wr_ok && awaddr_q == REG_STATUS;
    assign wr_pwrc = wr_go && wr_ok && awaddr_q == REG_PWRC;
    assign wr_push = wr_go && wr_ok && awaddr_q == REG_STACK;
    assign wr_maddr = wr_go && wr_ok && awaddr_q == REG_MADDR;
    assign wr_mdata = wr_go && wr_ok && awaddr_q == REG_MDATA;

    // execution decode
    lmie_op_t op;
    logic exec, soft_rst, stf, stf_core, ind_store, ind_sel;
    logic [6:0] fsel;
    lmie_ind_req_t ind_req;
    lmie_ind_res_t ind_res;
    assign op = decode(instr_q);
    assign exec = (state_q == ST_EXEC);
    assign soft_rst = exec && op == OP_RESET;
    assign fsel = instr_q[6:0];
    assign stf = exec && op == OP_STF;
    assign stf_core = stf && fsel <= F_CORE_LAST;
    // window registers have no storage, so they turn into an indirect store
    assign ind_store = exec && (op == OP_STIND || op == OP_STREL)
        || stf && (fsel == F_IND0 || fsel == F_IND1);
    assign ind_sel = (op == OP_STIND) ? instr_q[2] : (op == OP_STREL) ? instr_q[6] : fsel[0];

    // window access is a relative store with zero offset
    always_comb
    begin
        ind_req.ptr = ind_sel ? fsr1_q : fsr0_q;
        ind_req.rel = (op != OP_STIND);
        ind_req.mode = instr_q[1:0];
        ind_req.offset = (op == OP_STREL) ? instr_q[5:0] : 6'h00;
    end

    lmie_index_unit u_index
    (
        .req(ind_req),
        .res(ind_res)
    );

    // sequencing; the return takes a second cycle to refill the pc
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
            state_q <= ST_IDLE;
        else
            unique case (state_q)
                ST_IDLE: state_q <= wr_instr ? ST_EXEC : ST_IDLE;
                ST_EXEC: state_q <= (op == OP_RETIRQ) ? ST_SECOND : ST_IDLE;
                ST_SECOND: state_q <= ST_IDLE;
            endcase
    end

    // instruction holding register
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
            instr_q <= 14'h0000;
        else if (wr_instr)
            instr_q <= wdata_q[13:0];
    end

    // accumulator
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST || soft_rst)
            wreg_q <= 8'h00;
        else if (exec && op == OP_LDACC)
            wreg_q <= instr_q[7:0];
        else if (stf_core && fsel == F_WREG)
            wreg_q <= wreg_q;
    end

    // bank select
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST || soft_rst)
            bank_q <= 5'h00;
        else if (exec && op == OP_LDBANK)
            bank_q <= instr_q[4:0];
        else if (stf_core && fsel == F_BANK)
            bank_q <= wreg_q[4:0];
    end

    // pc high latch
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST || soft_rst)
            pglat_q <= 7'h00;
        else if (exec && op == OP_LDPAGE)
            pglat_q <= instr_q[6:0];
        else if (stf_core && fsel == F_PGLAT)
            pglat_q <= wreg_q[6:0];
    end

    // pointers: stepped only by the coded indirect form, bytes writable directly
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST || soft_rst)
        begin
            fsr0_q <= 16'h0000;
            fsr1_q <= 16'h0000;
        end
        else if (exec && op == OP_STIND)
        begin
            if (ind_sel)
                fsr1_q <= ind_res.nxt;
            else
                fsr0_q <= ind_res.nxt;
        end
        else if (stf_core)
        begin
            if (fsel == F_FSR0L) fsr0_q[7:0] <= wreg_q;
            if (fsel == F_FSR0H) fsr0_q[15:8] <= wreg_q;
            if (fsel == F_FSR1L) fsr1_q[7:0] <= wreg_q;
            if (fsel == F_FSR1H) fsr1_q[15:8] <= wreg_q;
        end
    end

    // program counter: every instruction but reset and return steps it, the return reloads it
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST || soft_rst)
            pc_q <= PC_RESET;
        else if (state_q == ST_SECOND)
            pc_q <= stack_q[SP_W'(sp_q - 1'b1)];
        else if (exec && op != OP_RETIRQ)
            pc_q <= 15'(pc_q + 1'b1);
    end

    // stack: software pushes return addresses, the return pops one
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST || soft_rst)
            sp_q <= '0;
        else if (state_q == ST_SECOND)
            sp_q <= SP_W'(sp_q - 1'b1);
        else if (wr_push)
            sp_q <= SP_W'(sp_q + 1'b1);
    end

    // stack storage has no reset, like data memory
    always_ff @(posedge CLK)
    begin
        if (wr_push)
            stack_q[sp_q] <= wdata_q[14:0];
    end

    // interrupt control; the return sets the global enable
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST || soft_rst)
            irqctl_q <= 8'h00;
        else if (state_q == ST_SECOND)
            irqctl_q[GEN_BIT] <= 1'b1;
        else if (stf_core && fsel == F_IRQCTL)
            irqctl_q <= wreg_q;
        else if (wr_irqctl)
            irqctl_q <= wdata_q[7:0];
    end

    // status flags: software writes them, hardware reset and the reset instruction clear them
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST || soft_rst)
            status_q <= 8'h00;
        else if (wr_status)
            status_q <= wdata_q[7:0];
    end

    // reset-instruction flag: the reset instruction's clear beats a software set
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
            rf_q <= RF_RESET;
        else if (soft_rst)
            rf_q <= 1'b0;
        else if (wr_pwrc && wdata_q[RF_BIT])
            rf_q <= 1'b1;
    end

    // data memory: file store, indirect store, or software window
    always_ff @(posedge CLK)
    begin
        if (ind_store)
            mem_q[ind_res.ea[MEM_AW-1:0]] <= wreg_q;
        else if (stf && !stf_core)
            mem_q[MEM_AW'({bank_q, fsel})] <= wreg_q;
        else if (wr_mdata)
            mem_q[maddr_q] <= wdata_q[7:0];
    end

    // software memory address
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
            maddr_q <= '0;
        else if (wr_maddr)
            maddr_q <= wdata_q[MEM_AW-1:0];
    end

    // write address and data are caught in either order
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            AWREADY <= 1'b1;
            WREADY <= 1'b1;
            awaddr_q <= 8'h00;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
        end
        else
        begin
            if (AWVALID && AWREADY)
            begin
                aw_held_q <= 1'b1;
                AWREADY <= 1'b0;
                awaddr_q <= AWADDR;
            end
            if (WVALID && WREADY)
            begin
                w_held_q <= 1'b1;
                WREADY <= 1'b0;
                wdata_q <= WDATA;
                wstrb_q <= WSTRB;
            end
            if (wr_go)
            begin
                aw_held_q <= 1'b0;
                w_held_q <= 1'b0;
            end
            if (BVALID && BREADY)
            begin
                AWREADY <= 1'b1;
                WREADY <= 1'b1;
            end
        end
    end

    // write response; partial strobes, busy or unmapped writes are refused
    logic wr_mapped;
    assign wr_mapped = (awaddr_q == REG_INSTR && state_q == ST_IDLE) || wr_irqctl
        || wr_status || wr_pwrc || wr_push || wr_maddr || wr_mdata;
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            BVALID <= 1'b0;
            BRESP <= RESP_OKAY;
        end
        else if (wr_go)
        begin
            BVALID <= 1'b1;
            BRESP <= (wr_ok && wr_mapped) ? RESP_OKAY : RESP_SLVERR;
        end
        else if (BVALID && BREADY)
            BVALID <= 1'b0;
    end

    // read mux, answered one cycle after the address is taken
    logic [31:0] rd_val;
    logic rd_hit;
    always_comb
    begin
        rd_val = 32'h0000_0000;
        rd_hit = 1'b1;
        unique case (ARADDR)
            REG_INSTR: rd_val = {(state_q != ST_IDLE), 17'h00000, instr_q};
            REG_WREG: rd_val = {24'h000000, wreg_q};
            REG_BANK: rd_val = {27'h0000000, bank_q};
            REG_PGLAT: rd_val = {25'h0000000, pglat_q};
            REG_FSR0: rd_val = {16'h0000, fsr0_q};
            REG_FSR1: rd_val = {16'h0000, fsr1_q};
            REG_PC: rd_val = {17'h00000, pc_q};
            REG_IRQCTL: rd_val = {24'h000000, irqctl_q};
            REG_STATUS: rd_val = {24'h000000, status_q};
            REG_PWRC: rd_val = {31'h00000000, rf_q};
            REG_STACK: rd_val = {8'h00, 8'(sp_q), 1'b0, stack_q[SP_W'(sp_q - 1'b1)]};
            REG_MADDR: rd_val = 32'(maddr_q);
            REG_MDATA: rd_val = {24'h000000, mem_q[maddr_q]};
            default: rd_hit = 1'b0;
        endcase
    end

    // read channels
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            ARREADY <= 1'b1;
            RVALID <= 1'b0;
            RDATA <= 32'h0000_0000;
            RRESP <= RESP_OKAY;
        end
        else if (ARVALID && ARREADY)
        begin
            ARREADY <= 1'b0;
            RVALID <= 1'b1;
            RDATA <= rd_val;
            RRESP <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end
        else if (RVALID && RREADY)
        begin
            RVALID <= 1'b0;
            ARREADY <= 1'b1;
        end
    end

endmodule : lmie_core

// File: rtl/lmie_pkg.sv
// Purpose: shared constants and types for the literal/move/indirect executor
// Assumes: 32-bit AXI4-Lite register access, one aligned word per register
// Notes: opcode patterns are matched as (word & mask) == pattern
package lmie_pkg;

    // register byte offsets
    localparam logic [7:0] REG_INSTR = 8'h00;
    localparam logic [7:0] REG_WREG = 8'h04;
    localparam logic [7:0] REG_BANK = 8'h08;
    localparam logic [7:0] REG_PGLAT = 8'h0c;
    localparam logic [7:0] REG_FSR0 = 8'h10;
    localparam logic [7:0] REG_FSR1 = 8'h14;
    localparam logic [7:0] REG_PC = 8'h18;
    localparam logic [7:0] REG_IRQCTL = 8'h1c;
    localparam logic [7:0] REG_STATUS = 8'h20;
    localparam logic [7:0] REG_PWRC = 8'h24;
    localparam logic [7:0] REG_STACK = 8'h28;
    localparam logic [7:0] REG_MADDR = 8'h2c;
    localparam logic [7:0] REG_MDATA = 8'h30;

    // field positions and reset values
    localparam int GEN_BIT = 7;
    localparam int RF_BIT = 0;
    localparam int BUSY_BIT = 31;
    localparam logic RF_RESET = 1'b1;
    localparam logic [14:0] PC_RESET = 15'h0000;

    // file addresses of the core registers, present in every bank
    localparam logic [6:0] F_IND0 = 7'h00;
    localparam logic [6:0] F_IND1 = 7'h01;
    localparam logic [6:0] F_CORE_LAST = 7'h0b;
    localparam logic [6:0] F_FSR0L = 7'h04;
    localparam logic [6:0] F_FSR0H = 7'h05;
    localparam logic [6:0] F_FSR1L = 7'h06;
    localparam logic [6:0] F_FSR1H = 7'h07;
    localparam logic [6:0] F_BANK = 7'h08;
    localparam logic [6:0] F_WREG = 7'h09;
    localparam logic [6:0] F_PGLAT = 7'h0a;
    localparam logic [6:0] F_IRQCTL = 7'h0b;

    // opcode patterns and masks, 14-bit instruction words
    localparam logic [13:0] OPC_NOP = 14'h0000;
    localparam logic [13:0] OPC_RESET = 14'h0001;
    localparam logic [13:0] OPC_RETIRQ = 14'h0009;
    localparam logic [13:0] MSK_FULL = 14'h3fff;
    localparam logic [13:0] OPC_LDBANK = 14'h0020;
    localparam logic [13:0] MSK_LDBANK = 14'h3fe0;
    localparam logic [13:0] OPC_LDPAGE = 14'h3180;
    localparam logic [13:0] OPC_LDACC = 14'h3000;
    localparam logic [13:0] MSK_LDACC = 14'h3f00;
    localparam logic [13:0] OPC_STF = 14'h0080;
    localparam logic [13:0] MSK_7BIT = 14'h3f80;
    localparam logic [13:0] OPC_STIND = 14'h0018;
    localparam logic [13:0] MSK_STIND = 14'h3ff8;
    localparam logic [13:0] OPC_STREL = 14'h3f80;

    // axi responses
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef enum logic [2:0]
    {
        ST_IDLE = 3'b001,
        ST_EXEC = 3'b010,
        ST_SECOND = 3'b100
    } lmie_state_t;

    typedef enum logic [3:0]
    {
        OP_NOP,
        OP_RESET,
        OP_RETIRQ,
        OP_LDBANK,
        OP_LDPAGE,
        OP_LDACC,
        OP_STF,
        OP_STIND,
        OP_STREL,
        OP_UNKNOWN
    } lmie_op_t;

    // request to the indirect address unit
    typedef struct packed {
        logic [15:0] ptr;
        logic rel;
        logic [1:0] mode;
        logic [5:0] offset;
    } lmie_ind_req_t;

    // effective address and pointer value after the store
    typedef struct packed {
        logic [15:0] ea;
        logic [15:0] nxt;
    } lmie_ind_res_t;

endpackage : lmie_pkg

// File: rtl/lmie_index_unit.sv
// Purpose: effective address and pointer update for indirect stores
// Assumes: purely combinational, sampled by the caller in one cycle
// Notes: 16-bit arithmetic wraps by construction
`timescale 1ns/1ps
module lmie_index_unit
(
    // pointer, mode and offset
    input lmie_pkg::lmie_ind_req_t req,
    // address and new pointer
    output lmie_pkg::lmie_ind_res_t res
);
    import lmie_pkg::*;

    logic [15:0] step;
    logic [15:0] stepped;
    logic [15:0] rel_addr;

    // odd mode codes step down; sums are cut to 16 bits so they wrap
    assign step = req.mode[0] ? 16'hffff : 16'h0001;
    assign stepped = 16'(req.ptr + step);
    assign rel_addr = 16'(req.ptr + {{10{req.offset[5]}}, req.offset});

    // pre modes address with the stepped value, post modes with the old one
    always_comb
    begin
        if (req.rel)
        begin
            res.ea = rel_addr;
            res.nxt = req.ptr;
        end
        else
        begin
            res.ea = req.mode[1] ? req.ptr : stepped;
            res.nxt = stepped;
        end
    end

endmodule : lmie_index_unit

// File: testbench/lmie_axi_master.sv
// Purpose: register bus master standing in for software on the far side
// Assumes: one write and one read at most, never both from one caller
// Notes: released payload lines show inverted data so stale values are not trusted
`timescale 1ns/1ps
module lmie_axi_master
(
    // clock
    input wire logic CLK,
    // write address and data
    output logic AWVALID,
    input wire logic AWREADY,
    output logic [7:0] AWADDR,
    output logic WVALID,
    input wire logic WREADY,
    output logic [31:0] WDATA,
    output logic [3:0] WSTRB,
    // write response
    input wire logic BVALID,
    output logic BREADY,
    input wire logic [1:0] BRESP,
    // read channels
    output logic ARVALID,
    input wire logic ARREADY,
    output logic [7:0] ARADDR,
    input wire logic RVALID,
    output logic RREADY,
    input wire logic [31:0] RDATA,
    input wire logic [1:0] RRESP
);
    // idle bus at time zero
    initial
    begin
        {AWVALID, WVALID, BREADY, ARVALID, RREADY} = 5'h0;
        {AWADDR, ARADDR, WDATA, WSTRB} = 52'h0;
    end

    // write: both channels offered together, each dropped when taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
        output logic [1:0] r);
        @(posedge CLK);
        {AWVALID, WVALID, BREADY} <= 3'h7;
        {AWADDR, WDATA, WSTRB} <= {a, d, s};
        forever
        begin
            @(posedge CLK);
            if (AWVALID && AWREADY)
                {AWVALID, AWADDR} <= {1'b0, ~AWADDR};
            if (WVALID && WREADY)
                {WVALID, WDATA, WSTRB} <= {1'b0, ~WDATA, ~WSTRB};
            if (BVALID)
            begin
                r = BRESP;
                BREADY <= 1'b0;
                break;
            end
        end
    endtask : wr

    // read: no cycle count assumed, the bench timeout ends a hang
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge CLK);
        {ARVALID, RREADY, ARADDR} <= {2'h3, a};
        forever
        begin
            @(posedge CLK);
            if (ARVALID && ARREADY)
                {ARVALID, ARADDR} <= {1'b0, ~ARADDR};
            if (RVALID)
            begin
                {d, r} = {RDATA, RRESP};
                RREADY <= 1'b0;
                break;
            end
        end
    endtask : rd
endmodule : lmie_axi_master

// File: testbench/lmie_core_assertions.sv
// Purpose: port-level checks of the executor's register bus
// Assumes: single clock domain, reset active high
// Notes: instruction effects are checked by the bench through reads
`timescale 1ns/1ps
module lmie_core_assertions
#(
    parameter int MEM_AW = 9,
    parameter int STACK_DEPTH = 16
)
(
    // clock and reset
    input wire logic CLK,
    input wire logic RST,
    // write channels
    input wire logic AWVALID,
    input wire logic AWREADY,
    input wire logic [7:0] AWADDR,
    input wire logic WVALID,
    input wire logic WREADY,
    input wire logic [31:0] WDATA,
    input wire logic [3:0] WSTRB,
    input wire logic BVALID,
    input wire logic BREADY,
    input wire logic [1:0] BRESP,
    // read channels
    input wire logic ARVALID,
    input wire logic ARREADY,
    input wire logic [7:0] ARADDR,
    input wire logic RVALID,
    input wire logic RREADY,
    input wire logic [31:0] RDATA,
    input wire logic [1:0] RRESP
);
    import lmie_pkg::*;
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (RST);
    // joint write handshake on one edge, a plain signal so && may combine it
    logic wtake;
    assign wtake = AWVALID && AWREADY && WVALID && WREADY;

    // readies drop first, the response follows one cycle later
    AST_B_ONE:
        assert property (wtake |=> !AWREADY && !WREADY ##1 BVALID)
        else $error("late write answer");
    AST_B_HOLD:
        assert property (BVALID && !BREADY |=> BVALID && $stable(BRESP)) else $error("bresp moved");
    AST_B_DONE:
        assert property (BVALID && BREADY |=> !BVALID ##1 AWREADY && WREADY)
        else $error("write side not freed");
    AST_R_ONE:
        assert property (ARVALID && ARREADY |=> RVALID && !ARREADY) else $error("late read");
    AST_R_HOLD:
        assert property (RVALID && !RREADY |=> $stable({RVALID, RDATA, RRESP}))
        else $error("read data moved");
    AST_R_DONE:
        assert property (RVALID && RREADY |=> !RVALID && ARREADY) else $error("read not freed");
    AST_UNMAPPED:
        assert property (ARVALID && ARREADY && ARADDR > REG_MDATA |=>
            RRESP == RESP_SLVERR && RDATA == 32'h0) else $error("unmapped read answered");
    AST_RO_WRITE:
        assert property (wtake && (AWADDR == REG_WREG || WSTRB != 4'hf) |=>
            ##1 BRESP == RESP_SLVERR) else $error("bad write accepted");

    // main traffic kinds
    COV_WRITE: cover property (BVALID && BREADY && BRESP == RESP_OKAY);
    COV_READ: cover property (RVALID && RREADY && RRESP == RESP_OKAY);
    COV_ERR: cover property (BVALID && BRESP == RESP_SLVERR);
endmodule : lmie_core_assertions

bind lmie_core lmie_core_assertions #(.MEM_AW(MEM_AW), .STACK_DEPTH(STACK_DEPTH))
    i_lmie_core_assertions (.CLK, .RST, .AWVALID, .AWREADY, .AWADDR, .WVALID, .WREADY,
    .WDATA, .WSTRB, .BVALID, .BREADY, .BRESP, .ARVALID, .ARREADY, .ARADDR, .RVALID,
    .RREADY, .RDATA, .RRESP);

// File: testbench/lmie_core_tb.sv
// Purpose: self-checking run of the executor through its register bus
// Assumes: master model drives every bus input, bench drives clock and reset
// Notes: rows carry the instruction stream, state carries over between rows
`timescale 1ns/1ps
`define LMIE_CHK(nm, ex, got) \
    begin \
        checks++; \
        if ((got) !== (ex)) \
        begin \
            $display("mismatch %s expected %h seen %h", nm, ex, got); \
            err_total++; \
        end \
    end
module lmie_core_tb;
    import lmie_pkg::*;
    // row kinds: write, read, execute, refused write, narrow write, unmapped read
    localparam logic [2:0] KW = 3'h0, KR = 3'h1, KX = 3'h2, KN = 3'h3, KS = 3'h4, KU = 3'h5;
    localparam int NR = 62;
    typedef struct packed {logic [2:0] k; logic [7:0] a; logic [31:0] d;} lmie_row_t;
    logic CLK, RST, AWVALID, AWREADY, WVALID, WREADY, BVALID, BREADY;
    logic ARVALID, ARREADY, RVALID, RREADY;
    logic [7:0] AWADDR, ARADDR;
    logic [31:0] WDATA, RDATA, got;
    logic [3:0] WSTRB;
    logic [1:0] BRESP, RRESP, rs;
    int err_total = 0, checks = 0, cyc = 0;
    // ordered stream; the pc expectation counts every executed row
    lmie_row_t rows [NR] = '{
        '{KR, REG_WREG, 32'h0}, '{KR, REG_PWRC, 32'h1}, '{KW, REG_STATUS, 32'ha5},
        '{KX, 8'h0, 32'h3f}, '{KR, REG_BANK, 32'h1f}, '{KX, 8'h0, 32'h31ff},
        '{KR, REG_PGLAT, 32'h7f}, '{KX, 8'h0, 32'h30ff}, '{KR, REG_WREG, 32'hff},
        '{KX, 8'h0, 32'h20}, '{KX, 8'h0, 32'h84}, '{KX, 8'h0, 32'h85},
        '{KR, REG_FSR0, 32'hffff}, '{KW, REG_MADDR, 32'h0}, '{KX, 8'h0, 32'h18},
        '{KR, REG_FSR0, 32'h0}, '{KR, REG_MDATA, 32'hff}, '{KX, 8'h0, 32'h3011},
        '{KX, 8'h0, 32'h1b}, '{KR, REG_FSR0, 32'hffff}, '{KR, REG_MDATA, 32'h11},
        '{KX, 8'h0, 32'h3022}, '{KX, 8'h0, 32'h19}, '{KR, REG_FSR0, 32'hfffe},
        '{KW, REG_MADDR, 32'h1fe}, '{KR, REG_MDATA, 32'h22}, '{KX, 8'h0, 32'h1e},
        '{KR, REG_FSR1, 32'h1}, '{KW, REG_MADDR, 32'h0}, '{KR, REG_MDATA, 32'h22},
        '{KX, 8'h0, 32'h3033}, '{KX, 8'h0, 32'h3fe0}, '{KR, REG_FSR1, 32'h1},
        '{KW, REG_MADDR, 32'h1e1}, '{KR, REG_MDATA, 32'h33}, '{KX, 8'h0, 32'h3044},
        '{KX, 8'h0, 32'h81}, '{KR, REG_FSR1, 32'h1}, '{KW, REG_MADDR, 32'h1},
        '{KR, REG_MDATA, 32'h44}, '{KX, 8'h0, 32'ha0}, '{KW, REG_MADDR, 32'h20},
        '{KR, REG_MDATA, 32'h44}, '{KX, 8'h0, 32'h0}, '{KR, REG_PC, 32'h12},
        '{KR, REG_STATUS, 32'ha5}, '{KR, REG_WREG, 32'h44}, '{KW, REG_STACK, 32'h155},
        '{KX, 8'h0, 32'h9}, '{KR, REG_PC, 32'h155}, '{KR, REG_IRQCTL, 32'h80},
        '{KN, REG_WREG, 32'h1}, '{KS, REG_STATUS, 32'h0}, '{KU, 8'hfc, 32'h0},
        '{KR, REG_STATUS, 32'ha5}, '{KX, 8'h0, 32'h1}, '{KR, REG_PWRC, 32'h0},
        '{KR, REG_WREG, 32'h0}, '{KR, REG_PC, 32'h0}, '{KR, REG_IRQCTL, 32'h0},
        '{KR, REG_STATUS, 32'h0}, '{KR, REG_MDATA, 32'h44}};

    lmie_core #(.MEM_AW(9), .STACK_DEPTH(16)) i_lmie_core (.CLK, .RST, .AWVALID, .AWREADY,
        .AWADDR, .WVALID, .WREADY, .WDATA, .WSTRB, .BVALID, .BREADY, .BRESP, .ARVALID,
        .ARREADY, .ARADDR, .RVALID, .RREADY, .RDATA, .RRESP);
    lmie_axi_master i_lmie_axi_master (.CLK, .AWVALID, .AWREADY, .AWADDR, .WVALID, .WREADY,
        .WDATA, .WSTRB, .BVALID, .BREADY, .BRESP, .ARVALID, .ARREADY, .ARADDR, .RVALID,
        .RREADY, .RDATA, .RRESP);

    // 100 MHz clock
    initial
    begin
        CLK = 1'b0;
        forever #5 CLK = ~CLK;
    end

    // verdict and end of run
    task automatic results;
        if (err_total == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : results

    // issue one instruction, then poll busy with a bounded count
    task automatic exec_instr(input logic [31:0] ins);
        int n;
        i_lmie_axi_master.wr(REG_INSTR, ins, 4'hf, rs);
        `LMIE_CHK("instr resp", RESP_OKAY, rs)
        n = 0;
        got = 32'h80000000;
        while (got[BUSY_BIT] !== 1'b0 && n < 10)
        begin
            i_lmie_axi_master.rd(REG_INSTR, got, rs);
            n++;
        end
        `LMIE_CHK("busy", 1'b0, got[BUSY_BIT])
    endtask : exec_instr

    // hang guard, far above the few hundred cycles the run needs
    always @(posedge CLK)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            err_total++;
            results();
        end
    end

    initial
    begin
        RST = 1'b1;
        repeat (2) @(posedge CLK);
        RST <= 1'b0;
        for (int i = 0; i < NR; i++)
        begin
            if (rows[i].k == KX)
                exec_instr(rows[i].d);
            else if (rows[i].k == KR || rows[i].k == KU)
            begin
                i_lmie_axi_master.rd(rows[i].a, got, rs);
                `LMIE_CHK("rdata", rows[i].d, got)
                `LMIE_CHK("rresp", (rows[i].k == KU) ? RESP_SLVERR : RESP_OKAY, rs)
            end
            else
            begin
                i_lmie_axi_master.wr(rows[i].a, rows[i].d, (rows[i].k == KS) ? 4'h3 : 4'hf, rs);
                `LMIE_CHK("bresp", (rows[i].k == KW) ? RESP_OKAY : RESP_SLVERR, rs)
            end
        end
        // hardware reset in mid-run sets the flag the software reset cleared
        @(posedge CLK);
        RST <= 1'b1;
        repeat (2) @(posedge CLK);
        RST <= 1'b0;
        i_lmie_axi_master.rd(REG_PWRC, got, rs);
        `LMIE_CHK("reset flag after reset", 32'h1, got)
        i_lmie_axi_master.rd(REG_PC, got, rs);
        `LMIE_CHK("pc after reset", 32'h0, got)
        results();
    end
endmodule : lmie_core_tb
